// ---- common/uart_params.svh ----
// Register addresses, field positions, reset values and bit timing counts
`ifndef UART_PARAMS_SVH
`define UART_PARAMS_SVH
// How it works
// [R1] FIFO enable bit; any toggle empties both FIFOs
// [R2] Software must set FIFO enable for operation
// [R3] Rx reset bit flushes rx FIFO, self-clears
// [R4] Tx reset bit flushes tx FIFO, self-clears
// [R5] Trigger select: 1, 4, 8, 14 characters
// [R6] Software writes reserved bits as zero
// [R7] Word length select five to eight bits
// [R8] Stop select: one, two, or one and half
// [R9] Parity enable for transmit and receive
// [R10] Parity type: odd, even, forced one, zero
// [R11] Break holds transmit line at zero
// [R12] Divisor access bit redirects shared offsets
// [R13] Line status is read-only, rx and tx; code reports receive flags only
// [R14] Data ready while receive FIFO not empty
// [R15] Overrun: drop character, set flag, read clears
// [R16] Parity error for head character, read clears
// [R17] Receive available follows fill versus trigger
// [R18] Divisor sets sixteen-times oversampling tick
// [R19] FIFO disabled: upper control bits not written
// [R20] Frame: start, data LSB first, parity, stop

`define ADDR_DATA      32'hE000C000
`define ADDR_DLM       32'hE000C004
`define ADDR_FCR       32'hE000C008
`define ADDR_LCR       32'hE000C00C
`define ADDR_LSR       32'hE000C014

`define FCR_EN_BIT     0
`define FCR_RXRST_BIT  1
`define FCR_TXRST_BIT  2
`define FCR_TRIG_LSB   6
`define LSR_DR_BIT     0
`define LSR_OE_BIT     1
`define LSR_PE_BIT     2

`define FCR_RESET      8'h00
`define LCR_RESET      8'h00
`define DLL_RESET      8'h01
`define DLM_RESET      8'h00

`define TRIG_LVL0      5'h01
`define TRIG_LVL1      5'h04
`define TRIG_LVL2      5'h08
`define TRIG_LVL3      5'h0E

`define FIFO_DEPTH     16
`define BIT_TICKS      6'h10
`define STOP15_TICKS   6'h18
`define STOP2_TICKS    6'h20
`define HALF_TICK_LAST 4'h7
`define BIT_TICK_LAST  4'hF
`endif

// ---- common/uart_pkg.sv ----
// Types and shared helpers for the serial port control block
package uart_pkg;
	// Line format fields, packed as the register holds them
	typedef struct packed {
		logic       dlab;   // Divisor latch access
		logic       brk;    // Break transmit
		logic [1:0] ptype;  // Parity type
		logic       pen;    // Parity enable
		logic       stb;    // Stop bit select
		logic [1:0] wls;    // Word length select
	} lcr_t;

	// One receive FIFO entry: data plus its parity verdict
	typedef struct packed {
		logic       perr;
		logic [7:0] data;
	} rx_entry_t;

	// Serialiser phases, shared by receiver and transmitter
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_START = 5'b00010,
		S_DATA  = 5'b00100,
		S_PAR   = 5'b01000,
		S_STOP  = 5'b10000
	} ser_state_t;

	// Mask of valid data bits for a word length code
	function automatic logic [7:0] len_mask(input logic [1:0] wls);
		len_mask = 8'hFF >> (~wls);
	endfunction

	// Parity bit for a character under the current format
	function automatic logic parity_of(input logic [7:0] d, input lcr_t c);
		logic x;
		x = ^(d & len_mask(c.wls));
		case (c.ptype)
			2'b00:   parity_of = ~x;   // Odd
			2'b01:   parity_of = x;    // Even
			2'b10:   parity_of = 1'b1; // Forced one
			default: parity_of = 1'b0; // Forced zero
		endcase
	endfunction
endpackage

// ---- sim/uart_ctrl_properties.sv ----
// Port-level assertions for the serial control block
`include "uart_params.svh"
module uart_ctrl_properties #(
	parameter int DEPTH = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [31:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        rx_avail_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	wire        acc    = psel && penable;            // Access phase
	wire        rd_acc = acc && !pwrite;             // Read access
	wire        wr_fcr = acc && pwrite && paddr == `ADDR_FCR;
	wire        wr_lcr = acc && pwrite && paddr == `ADDR_LCR;
	logic [7:0] lcr_ff;                              // Shadow line format
	logic       fen_ff;                              // Shadow FIFO enable
	logic [1:0] trig_ff;                             // Shadow trigger select

	// Shadow copy; upper FIFO bits only stick with enable written high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcr_ff <= 8'h00;
			fen_ff <= 1'b0;
			trig_ff <= 2'h0;
		end else begin
			if (wr_lcr) lcr_ff <= pwdata[7:0];
			if (wr_fcr) fen_ff <= pwdata[0];
			if (wr_fcr && pwdata[0]) trig_ff <= pwdata[7:6];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	dlm_locked_a: assert property (
		acc && paddr == `ADDR_DLM && !lcr_ff[7] |-> pslverr)
		else $error("divisor high open while latch access off");
	dlm_open_a: assert property (
		acc && paddr == `ADDR_DLM && lcr_ff[7] |-> !pslverr)
		else $error("divisor high refused while latch access on");
	lsr_upper_zero_a: assert property (
		rd_acc && paddr == `ADDR_LSR |-> prdata[31:3] == 29'h00000000)
		else $error("status upper bits not zero");
	fcr_readback_a: assert property (
		rd_acc && paddr == `ADDR_FCR |-> prdata == {24'h000000, trig_ff, 5'h00, fen_ff})
		else $error("FIFO control readback wrong");
	lcr_readback_a: assert property (
		rd_acc && paddr == `ADDR_LCR |-> prdata == {24'h000000, lcr_ff})
		else $error("line control readback wrong");
	dr_matches_irq_a: assert property (
		rd_acc && paddr == `ADDR_LSR && (!fen_ff || trig_ff == 2'h0) |-> prdata[0] == rx_avail_irq)
		else $error("data ready disagrees with receive level");
	fen_flush_a: assert property (
		wr_fcr && pwdata[0] != fen_ff |-> ##3 !rx_avail_irq)
		else $error("enable toggle did not empty receive FIFO");
	rx_flush_a: assert property (
		wr_fcr && pwdata[0] && pwdata[1] |-> ##3 !rx_avail_irq)
		else $error("receive reset did not empty receive FIFO");
	break_low_a: assert property (
		lcr_ff[6] |-> !txd)
		else $error("transmit line high during break");
endmodule

bind uart_ctrl uart_ctrl_properties #(.DEPTH(DEPTH)) chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
	.rx_avail_irq(rx_avail_irq));

// ---- sim/uart_ctrl_test.sv ----
// Self-checking bench for the serial control block
`include "uart_params.svh"
module test_uart_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	import uart_pkg::*;
	localparam logic [31:0] ADDR_HOLE = 32'hE000C010;  // Unmapped offset
	localparam int          LIMIT     = 40000;         // Cycle ceiling
	logic        pclk, presetn, psel, penable, pwrite, rxd, txd, pready, pslverr, rx_avail_irq;
	logic [31:0] paddr, pwdata, prdata;
	int          fails, checked, cycles;

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	uart_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .rx_avail_irq(rx_avail_irq));
	uart_remote rem (.pclk(pclk), .line_in(txd), .line_out(rxd));

	task automatic print_verdict();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready seen at an edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		check(r, exp);
	endtask

	task automatic err_chk(input logic [31:0] a, input logic exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		check({31'h00000000, e}, {31'h00000000, exp});
	endtask

	// Valid data bits for a length code
	function automatic logic [7:0] msk(input logic [1:0] wls);
		msk = 8'h00;
		for (int k = 0; k < 5 + wls; k++) msk[k] = 1'b1;
	endfunction

	// Expected parity bit; odd means total ones odd
	function automatic logic par(input logic [7:0] d, input logic [1:0] wls, input logic [1:0] pt);
		logic x;
		x = ^(d & msk(wls));
		case (pt)
			2'h0: par = ~x;
			2'h1: par = x;
			2'h2: par = 1'b1;
			default: par = 1'b0;
		endcase
	endfunction

	// Reset values and refused places
	task automatic t_reset();
		rd_chk(`ADDR_FCR, 32'h00000000);
		rd_chk(`ADDR_LCR, 32'h00000000);
		rd_chk(`ADDR_LSR, 32'h00000000);
		err_chk(ADDR_HOLE, 1'b1);
		err_chk(`ADDR_DLM, 1'b1);
	endtask

	// Control fields: gating, self-clear, latch access, break
	task automatic t_regs();
		wr(`ADDR_FCR, 8'hC6);
		rd_chk(`ADDR_FCR, 32'h00000000);
		wr(`ADDR_FCR, 8'h81);
		rd_chk(`ADDR_FCR, 32'h00000081);
		wr(`ADDR_FCR, 8'h47);
		rd_chk(`ADDR_FCR, 32'h00000041);
		wr(`ADDR_FCR, 8'h80);
		rd_chk(`ADDR_FCR, 32'h00000040);
		wr(`ADDR_LCR, 8'h80);
		err_chk(`ADDR_DLM, 1'b0);
		wr(`ADDR_LCR, 8'h3F);
		rd_chk(`ADDR_LCR, 32'h0000003F);
		wr(`ADDR_LCR, 8'h40);
		repeat (3) @(posedge pclk);
		check({31'h00000000, txd}, 32'h00000000);
		wr(`ADDR_LCR, 8'h00);
		repeat (3) @(posedge pclk);
		check({31'h00000000, txd}, 32'h00000001);
	endtask

	// Divisor latch readback and a doubled bit time on the line
	task automatic t_baud();
		int n = 0;
		wr(`ADDR_LCR, 8'h83);
		wr(`ADDR_DATA, 8'h02);
		rd_chk(`ADDR_DATA, 32'h00000002);
		wr(`ADDR_LCR, 8'h03);
		wr(`ADDR_DATA, 8'h01);
		while (txd !== 1'b0) @(posedge pclk);
		do begin
			@(posedge pclk);
			n++;
		end while (txd === 1'b0);
		check(32'((n + 1) / 2), 32'h00000010);
		wr(`ADDR_LCR, 8'h83);
		wr(`ADDR_DATA, 8'h01);
	endtask

	// Every length, parity type and stop choice, both directions
	task automatic t_frames();
		logic [1:0] wls, pt;
		logic [7:0] d, g1, g2;
		logic       stb, pen, p, q1, q2;
		int         n, s1, stp;
		wr(`ADDR_FCR, 8'h01);
		for (int i = 0; i < 9; i++) begin
			wls = i[1:0];
			stb = i[2];
			pt = i[2:1];
			pen = (i < 8);
			n = 5 + wls;
			d = (8'h5A + 8'(i) * 8'h37) & msk(wls);
			p = par(d, wls, pt);
			wr(`ADDR_LCR, {2'b00, pt, pen, stb, wls});
			rem.send(d, n, pen, p);
			rd_chk(`ADDR_DATA, {24'h000000, d});
			rd_chk(`ADDR_LSR, 32'h00000000);
			if (pen) begin
				rem.send(d, n, 1'b1, ~p);
				rd_chk(`ADDR_LSR, 32'h00000005);
				rd_chk(`ADDR_DATA, {24'h000000, d});
				rd_chk(`ADDR_LSR, 32'h00000000);
			end
			fork
				begin
					wr(`ADDR_DATA, d);
					wr(`ADDR_DATA, ~d & msk(wls));
				end
				begin
					rem.listen(n, pen, g1, q1);
					s1 = rem.start_cyc;
					rem.listen(n, pen, g2, q2);
				end
			join
			stp = stb ? ((wls == 2'h0) ? 24 : 32) : 16;
			check({24'h000000, g1}, {24'h000000, d});
			check({24'h000000, g2}, {24'h000000, ~d & msk(wls)});
			check({31'h00000000, q1}, {31'h00000000, pen & p});
			// Transmitter idles one clock between back-to-back frames
			check(rem.start_cyc - s1, 16 * (1 + n + pen) + stp + 1);
		end
	endtask

	// Fill past full, drain, trigger table, flushes
	task automatic t_fill();
		int lvl[4] = '{1, 4, 8, 14};
		wr(`ADDR_LCR, 8'h03);
		wr(`ADDR_FCR, 8'h41);
		for (int k = 0; k < 16; k++) begin
			rem.send(8'h30 + 8'(k), 8, 1'b0, 1'b0);
			if (k == 2) check({31'h00000000, rx_avail_irq}, 32'h00000000);
			if (k == 3) check({31'h00000000, rx_avail_irq}, 32'h00000001);
		end
		rem.send(8'hEE, 8, 1'b0, 1'b0);
		rd_chk(`ADDR_LSR, 32'h00000003);
		rd_chk(`ADDR_LSR, 32'h00000001);
		for (int k = 0; k < 16; k++) begin
			rd_chk(`ADDR_DATA, 32'h00000030 + k);
			repeat (2) @(posedge pclk);
			if (k == 12) check({31'h00000000, rx_avail_irq}, 32'h00000000);
		end
		rd_chk(`ADDR_LSR, 32'h00000000);
		for (int t = 0; t < 4; t++) begin
			wr(`ADDR_FCR, {2'(t), 6'h01});
			for (int k = 0; k < lvl[t] - 1; k++) rem.send(8'h11, 8, 1'b0, 1'b0);
			check({31'h00000000, rx_avail_irq}, 32'h00000000);
			rem.send(8'h22, 8, 1'b0, 1'b0);
			check({31'h00000000, rx_avail_irq}, 32'h00000001);
			wr(`ADDR_FCR, {2'(t), 6'h03});
			rd_chk(`ADDR_LSR, 32'h00000000);
		end
		wr(`ADDR_FCR, 8'h01);
		rem.send(8'h33, 8, 1'b0, 1'b0);
		wr(`ADDR_FCR, 8'h00);
		rd_chk(`ADDR_LSR, 32'h00000000);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_baud();
		t_frames();
		t_fill();
		print_verdict();
	end
endmodule

// ---- sim/uart_remote.sv ----
// Remote serial device: sends frames to the block and captures its frames
module uart_remote #(
	parameter int BIT_CYC = 16
) (
	input  wire logic pclk,
	input  wire logic line_in,
	output logic      line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc;        // Free cycle count
	int start_cyc;  // Cycle of last start seen

	initial line_out = 1'b1;
	// Cycle count for frame spacing
	always @(posedge pclk) cyc <= cyc + 1;

	// One bit time at the line
	task automatic put_bit(input logic v);
		line_out <= v;
		repeat (BIT_CYC) @(posedge pclk);
	endtask

	// Start, data low bit first, optional parity, one stop
	task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pbit);
		@(posedge pclk);
		put_bit(1'b0);
		for (int k = 0; k < n; k++) put_bit(d[k]);
		if (pen) put_bit(pbit);
		put_bit(1'b1);
		repeat (4) @(posedge pclk);
	endtask

	// Mid-bit capture; returns at mid stop so the next start is seen
	task automatic listen(input int n, input logic pen, output logic [7:0] d, output logic p);
		d = 8'h00;
		p = 1'b0;
		@(posedge pclk);
		while (line_in !== 1'b0) @(posedge pclk);
		start_cyc = cyc;
		repeat (BIT_CYC / 2) @(posedge pclk);
		for (int k = 0; k < n; k++) begin
			repeat (BIT_CYC) @(posedge pclk);
			d[k] = line_in;
		end
		if (pen) begin
			repeat (BIT_CYC) @(posedge pclk);
			p = line_in;
		end
		repeat (BIT_CYC) @(posedge pclk);
	endtask
endmodule

// ---- verilog/uart_ctrl.sv ----
// Serial port control: APB registers, baud tick, receiver, status flags
`include "uart_params.svh"
module uart_ctrl #(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             rx_avail_irq
);
	import uart_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);

	// Registers
	logic        fen_ff;          // FIFO enable
	logic [1:0]  trig_ff;         // Receive trigger select
	lcr_t        lcr_ff;          // Line format
	logic [7:0]  dll_ff;          // Divisor low latch
	logic [7:0]  dlm_ff;          // Divisor high latch
	logic        oe_ff;           // Overrun flag
	logic        pe_ff;           // Parity error flag
	logic [31:0] prdata_ff;       // Read data, captured in setup
	logic        irq_ff;          // Receive available level

	// Baud generator
	logic [15:0] bcnt_ff;         // Divider count
	logic        tick_ff;         // Sixteen-times enable

	// Receiver
	logic        rx_s1_ff;        // Synchroniser first stage
	logic        rx_s2_ff;        // Synchroniser second stage
	ser_state_t  rst_ff;          // Receive phase
	logic [3:0]  rcnt_ff;         // Ticks within a bit
	logic [2:0]  rbit_ff;         // Data bit index
	logic [7:0]  rsh_ff;          // Receive shift register
	logic        rpar_ff;         // Sampled parity bit
	logic        rdone_ff;        // Character assembled pulse
	rx_entry_t   rchar_ff;        // Assembled character
	logic        head_new_ff;     // New character reached FIFO head

	// FIFO links
	rx_entry_t   rx_head;
	logic [CW-1:0] rx_cnt;
	logic [CW-1:0] tx_cnt;
	logic [7:0]  tx_head;
	logic        tx_take;
	logic        tx_line;

	// Bus decode
	wire setup   = psel && !penable;
	wire access  = psel && penable;
	wire wr      = access && pwrite;
	wire rd      = access && !pwrite;
	wire sel_dat = (paddr == `ADDR_DATA);
	wire sel_dlm = (paddr == `ADDR_DLM) && lcr_ff.dlab;
	wire sel_fcr = (paddr == `ADDR_FCR);
	wire sel_lcr = (paddr == `ADDR_LCR);
	wire sel_lsr = (paddr == `ADDR_LSR);
	wire hit     = sel_dat || sel_dlm || sel_fcr || sel_lcr || sel_lsr;
	// Shared offsets steer to divisor latches while dlab is set
	wire wr_dll  = wr && sel_dat && lcr_ff.dlab;  // [R12]
	wire wr_thr  = wr && sel_dat && !lcr_ff.dlab; // [R12]
	wire rd_rbr  = rd && sel_dat && !lcr_ff.dlab; // [R12]
	wire wr_dlm  = wr && sel_dlm;
	wire wr_fcr  = wr && sel_fcr;
	wire wr_lcr  = wr && sel_lcr;
	// Status register has no write effect
	wire rd_lsr  = rd && sel_lsr;                 // [R13]

	// FIFO control write effects
	wire fen_new  = pwdata[`FCR_EN_BIT];
	wire fen_chg  = wr_fcr && (fen_new != fen_ff);            // [R1]
	wire upper_ok = wr_fcr && fen_new;                        // [R19]
	// Reset bits act as pulses and never store
	wire rx_flush = fen_chg || (upper_ok && pwdata[`FCR_RXRST_BIT]); // [R3]
	wire tx_flush = fen_chg || (upper_ok && pwdata[`FCR_TXRST_BIT]); // [R4]

	// Effective capacity: one character when FIFOs are disabled
	wire rx_full  = fen_ff ? (rx_cnt == CW'(DEPTH)) : (rx_cnt != '0);
	wire tx_full  = fen_ff ? (tx_cnt == CW'(DEPTH)) : (tx_cnt != '0);
	wire rx_push  = rdone_ff && !rx_full;                     // [R15]
	wire ovr_evt  = rdone_ff && rx_full;                      // [R15]
	wire rx_pop   = rd_rbr;
	wire data_rdy = (rx_cnt != '0);                           // [R14]

	// Trigger depth from select code
	wire [4:0] trig_lvl = (trig_ff == 2'b00) ? `TRIG_LVL0 :
		(trig_ff == 2'b01) ? `TRIG_LVL1 :
		(trig_ff == 2'b10) ? `TRIG_LVL2 : `TRIG_LVL3;           // [R5]

	// Head changes on push into empty FIFO without a same-cycle data read, or pop leaving more behind
	wire head_chg = (rx_push && (rx_cnt == '0) && !rx_pop) ||
		(rx_pop && (rx_cnt > CW'(1)));
	wire pe_evt   = head_new_ff && rx_head.perr && (rx_cnt != '0); // [R16]

	// Line status image; same-cycle events show so a clearing read never drops one
	wire [7:0] lsr_val = {5'h00, pe_ff | pe_evt, oe_ff | ovr_evt, data_rdy}; // [R13]
	wire [7:0] fcr_val = {trig_ff, 5'h00, fen_ff};            // [R6]

	// Read mux, sampled into prdata during setup
	wire [7:0] rd_mux = !sel_dat ? (sel_dlm ? dlm_ff :
		sel_fcr ? fcr_val : sel_lcr ? lcr_ff : sel_lsr ? lsr_val : 8'h00) :
		(lcr_ff.dlab ? dll_ff : rx_head.data);

	wire [15:0] divisor  = {dlm_ff, dll_ff};
	wire        rx_line  = rx_s2_ff;
	wire        rx_bend  = tick_ff && (rcnt_ff == `BIT_TICK_LAST);
	wire        rx_lastb = (rbit_ff == {1'b0, lcr_ff.wls} + 3'h4);
	wire [7:0]  rx_data  = rsh_ff >> (~lcr_ff.wls);           // Right-justify short words

	// Zero-wait slave; errors for unmapped addresses and for DLM while dlab is clear
	assign pready       = 1'b1;
	assign pslverr      = access && !hit;
	assign prdata       = prdata_ff;
	assign rx_avail_irq = irq_ff;
	// Break overrides the serialiser output
	assign txd          = lcr_ff.brk ? 1'b0 : tx_line;         // [R11]

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fen_ff  <= 1'(`FCR_RESET >> `FCR_EN_BIT);
			trig_ff <= 2'(`FCR_RESET >> `FCR_TRIG_LSB);
			lcr_ff  <= `LCR_RESET;
			dll_ff  <= `DLL_RESET;
			dlm_ff  <= `DLM_RESET;
		end else begin
			if (wr_fcr)
				fen_ff <= fen_new;                             // [R1]
			if (upper_ok)
				trig_ff <= pwdata[`FCR_TRIG_LSB +: 2];         // [R19]
			if (wr_lcr)
				lcr_ff <= pwdata[7:0];                         // [R7]
			if (wr_dll)
				dll_ff <= pwdata[7:0];
			if (wr_dlm)
				dlm_ff <= pwdata[7:0];
		end
	end

	// Read data capture; held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= '0;
		else if (setup && !pwrite)
			prdata_ff <= {24'h000000, rd_mux};
	end

	// Error flags: a new event beats a same-cycle status read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_ff <= 1'b0;
			pe_ff <= 1'b0;
		end else begin
			if (ovr_evt)
				oe_ff <= 1'b1;                                 // [R15]
			else if (rd_lsr)
				oe_ff <= 1'b0;                                 // [R15]
			if (pe_evt)
				pe_ff <= 1'b1;                                 // [R16]
			else if (rd_lsr)
				pe_ff <= 1'b0;                                 // [R16]
		end
	end

	// Head tracking and receive available level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_new_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			head_new_ff <= head_chg && !rx_flush;
			irq_ff      <= fen_ff ? (rx_cnt >= CW'(trig_lvl)) : data_rdy; // [R17]
		end
	end

	// Divider: one tick every divisor clocks, none at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (divisor == 16'h0000) begin
			bcnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (bcnt_ff >= divisor - 16'h0001) begin
			bcnt_ff <= '0;
			tick_ff <= 1'b1;                                   // [R18]
		end else begin
			bcnt_ff <= bcnt_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	// Two-stage synchroniser on the serial input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
		end else begin
			rx_s1_ff <= rxd;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	// Receive sequencer; samples each bit at its middle tick.
	// Only the first stop bit is checked for timing, so a
	// two-stop sender is accepted without extra delay.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_ff   <= S_IDLE;
			rcnt_ff  <= '0;
			rbit_ff  <= '0;
			rsh_ff   <= '0;
			rpar_ff  <= 1'b0;
			rdone_ff <= 1'b0;
			rchar_ff <= '0;
		end else begin
			rdone_ff <= 1'b0;
			if (tick_ff)
				rcnt_ff <= rcnt_ff + 4'h1;
			case (rst_ff)
				S_IDLE: if (!rx_line) begin
					rst_ff  <= S_START;                        // [R20]
					rcnt_ff <= '0;
				end
				S_START: if (tick_ff && rcnt_ff == `HALF_TICK_LAST) begin
					// False start glitch returns to idle
					rst_ff  <= rx_line ? S_IDLE : S_DATA;
					rcnt_ff <= '0;
					rbit_ff <= '0;
				end
				S_DATA: if (rx_bend) begin
					rsh_ff  <= {rx_line, rsh_ff[7:1]};         // LSB first [R20]
					rbit_ff <= rbit_ff + 3'h1;
					if (rx_lastb)
						rst_ff <= lcr_ff.pen ? S_PAR : S_STOP; // [R9]
				end
				S_PAR: if (rx_bend) begin
					rpar_ff <= rx_line;
					rst_ff  <= S_STOP;
				end
				S_STOP: if (rx_bend) begin
					rst_ff        <= S_IDLE;
					rdone_ff      <= 1'b1;
					rchar_ff.data <= rx_data & len_mask(lcr_ff.wls); // [R7]
					rchar_ff.perr <= lcr_ff.pen &&
						(rpar_ff != parity_of(rx_data, lcr_ff)); // [R10]
				end
				default: rst_ff <= S_IDLE;
			endcase
		end
	end

	// Receive FIFO: data plus parity verdict per character
	uart_fifo #(
		.WIDTH ($bits(rx_entry_t)),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.pclk    (pclk),
		.presetn (presetn),
		.flush   (rx_flush),
		.push    (rx_push),
		.din     (rchar_ff),
		.pop     (rx_pop),
		.dout    (rx_head),
		.count   (rx_cnt)
	);

	// Transmit FIFO; a write to a full FIFO is dropped
	uart_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.pclk    (pclk),
		.presetn (presetn),
		.flush   (tx_flush),
		.push    (wr_thr && !tx_full),
		.din     (pwdata[7:0]),
		.pop     (tx_take),
		.dout    (tx_head),
		.count   (tx_cnt)
	);

	// Transmit serialiser
	uart_tx u_tx (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick_ff),
		.cfg     (lcr_ff),
		.valid   (tx_cnt != '0),
		.data    (tx_head),
		.take    (tx_take),
		.txd     (tx_line)
	);
endmodule

// ---- verilog/uart_fifo.sv ----
// Synchronous FIFO with flush, used for both receive and transmit
module uart_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] din,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] dout,
	output logic      [CW-1:0]    count
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];   // Storage, not reset
	logic [AW-1:0]    wp_ff;         // Write pointer
	logic [AW-1:0]    rp_ff;         // Read pointer
	logic [CW-1:0]    cnt_ff;        // Fill level

	wire do_push = push && (cnt_ff != CW'(DEPTH));
	wire do_pop  = pop && (cnt_ff != '0);

	// Pointer advance with wrap for any depth
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	assign dout  = mem[rp_ff];
	assign count = cnt_ff;

	// Storage write, skipped on flush; flush resets pointers and count, not storage
	always_ff @(posedge pclk) begin
		if (do_push && !flush)
			mem[wp_ff] <= din;
	end

	// Pointers and fill level; flush wins over traffic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_push)
				wp_ff <= inc(wp_ff);
			if (do_pop)
				rp_ff <= inc(rp_ff);
			cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule

// ---- verilog/uart_tx.sv ----
// Transmit serialiser driven by the sixteen-times tick
`include "uart_params.svh"
module uart_tx (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           tick,
	input  uart_pkg::lcr_t      cfg,
	input  wire logic           valid,
	input  wire logic [7:0]     data,
	output logic                take,
	output logic                txd
);
	import uart_pkg::*;

	ser_state_t st_ff;             // Frame phase
	logic [5:0] cnt_ff;            // Ticks within a bit
	logic [2:0] bit_ff;            // Data bit index
	logic [7:0] sh_ff;             // Shift register
	logic       par_ff;            // Parity of loaded byte
	logic       txd_ff;            // Registered line level

	// Stop length in ticks: one, one and half, two
	wire [5:0] stop_len = !cfg.stb ? `BIT_TICKS :
		(cfg.wls == 2'b00) ? `STOP15_TICKS : `STOP2_TICKS; // [R8]
	wire [5:0] lim      = (st_ff == S_STOP) ? stop_len : `BIT_TICKS;
	wire       bit_end  = tick && (cnt_ff == lim - 6'h01);
	wire       last_bit = (bit_ff == {1'b0, cfg.wls} + 3'h4); // [R7]

	assign take = (st_ff == S_IDLE) && valid;
	assign txd  = txd_ff;

	// Frame sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff  <= S_IDLE;
			cnt_ff <= '0;
			bit_ff <= '0;
			sh_ff  <= '0;
			par_ff <= 1'b0;
		end else begin
			cnt_ff <= bit_end ? 6'h00 : (tick ? cnt_ff + 6'h01 : cnt_ff);
			case (st_ff)
				S_IDLE: if (take) begin
					st_ff  <= S_START; // [R20]
					cnt_ff <= '0;
					sh_ff  <= data;
					par_ff <= parity_of(data, cfg); // [R10]
				end
				S_START: if (bit_end) begin
					st_ff  <= S_DATA;
					bit_ff <= '0;
				end
				S_DATA: if (bit_end) begin
					sh_ff  <= {1'b0, sh_ff[7:1]}; // LSB first [R20]
					bit_ff <= bit_ff + 3'h1;
					if (last_bit)
						st_ff <= cfg.pen ? S_PAR : S_STOP; // [R9]
				end
				S_PAR: if (bit_end)
					st_ff <= S_STOP;
				S_STOP: if (bit_end)
					st_ff <= S_IDLE;
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	// Line level, registered so the pin never glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			txd_ff <= 1'b1;
		else
			case (st_ff)
				S_START: txd_ff <= 1'b0;
				S_DATA:  txd_ff <= sh_ff[0];
				S_PAR:   txd_ff <= par_ff;
				default: txd_ff <= 1'b1;
			endcase
	end
endmodule
